/* core/rps_out_select.sv */
`timescale 1ns/100ps
// Summary of operation
// - Bits 12:8 of register one select pin 19.
// - Bits 4:0 of register one select pin 18.
// - Bits 12:8 of register two select pin 21.
// - Bits 4:0 of register two select pin 20.
// - Bits 15:13, 7:5 read zero, ignore writes.
// - All selection bits clear at reset.
// - Registers and pins exist on large package only.
module rps_out_select #(
	parameter bit LARGE_PKG = 1'b1
) (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic [3:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [3:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [31:0]           periph_out,
	input  wire logic [31:0]           periph_oe,
	input  wire logic [3:0]            port_out,
	input  wire logic [3:0]            port_oe,
	output logic [3:0]                 pin_out,
	output logic [3:0]                 pin_oe,
	output logic [3:0]                 pin_remapped
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] wd,
	                                        input logic [3:0]  be);
		logic [15:0] v;
		v = old;
		if (be[0]) begin
			v[7:0] = wd[7:0];
		end
		if (be[1]) begin
			v[15:8] = wd[15:8];
		end
		// Only the low two byte lanes exist; strobes 2 and 3 do nothing.
		// unimplemented bits masked
		merge16 = v & rps_pkg::SEL_MASK;
	endfunction

	// Only the two selection words answer; every other address is refused.
	function automatic logic is_mapped(input logic [3:0] a);
		is_mapped = LARGE_PKG && (a == rps_pkg::SEL_18_19_ADDR ||
		            a == rps_pkg::SEL_20_21_ADDR);
	endfunction

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------

	// Register one carries the selections for pins 18 and 19.
	function automatic logic hits_lo(input logic [3:0] a);
		hits_lo = LARGE_PKG && a == rps_pkg::SEL_18_19_ADDR;
	endfunction

	// Register two carries the selections for pins 20 and 21.
	function automatic logic hits_hi(input logic [3:0] a);
		hits_hi = LARGE_PKG && a == rps_pkg::SEL_20_21_ADDR;
	endfunction

	// Read word for an address; upper half and gaps always read zero.
	function automatic logic [31:0] read_word(input logic [3:0]  a,
	                                          input logic [15:0] lo,
	                                          input logic [15:0] hi);
		logic [31:0] w;
		w = '0;
		if (hits_lo(a)) begin
			w = 32'(lo & rps_pkg::SEL_MASK);
		end
		if (hits_hi(a)) begin
			w = 32'(hi & rps_pkg::SEL_MASK);
		end
		read_word = w;
	endfunction

	// A selection field sits at a fixed offset within its register.
	function automatic logic [4:0] field(input logic [15:0] r,
	                                     input int          lsb);
		field = r[lsb +: rps_pkg::SEL_W];
	endfunction

	// ------------------------------------------------------------------
	// Peripheral function lookup
	// ------------------------------------------------------------------

	// Value a pin drives when its selection is applied. Every code stays
	// in range: the field is five bits and the table holds all 32 codes.
	function automatic logic pick(input logic [4:0]  sel,
	                              input logic [31:0] func,
	                              input logic        port);
		if (!LARGE_PKG || sel == rps_pkg::SEL_NONE) begin
			pick = port;
		end else begin
			pick = func[sel];
		end
	endfunction

	// ------------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------------
	logic        aw_held_r;
	logic [3:0]  aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic [15:0] sel_lo_r;
	logic [15:0] sel_hi_r;
	logic        wr_go;

	// Both readies stay low while a response waits, so at most one write
	// is in flight and the holding stages never overrun.
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

	// Address and data are taken in either order; each waits in its
	// holding stage until the other arrives.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// Write strobes are stored with the data and applied at commit.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sel_lo_r <= rps_pkg::SEL_RESET;
		end else if (wr_go && hits_lo(aw_addr_r)) begin
			sel_lo_r <= merge16(sel_lo_r, w_data_r, w_strb_r);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sel_hi_r <= rps_pkg::SEL_RESET;
		end else if (wr_go && hits_hi(aw_addr_r)) begin
			sel_hi_r <= merge16(sel_hi_r, w_data_r, w_strb_r);
		end
	end

	// ------------------------------------------------------------------
	// Write response
	// ------------------------------------------------------------------

	// The response stands until bready is seen at an edge.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Unmapped writes are refused with an error and change nothing.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_bresp <= rps_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bresp <= is_mapped(aw_addr_r) ? rps_pkg::RESP_OKAY
			                                    : rps_pkg::RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	// The read answer stands until rready is seen; arready is low meanwhile.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Unmapped reads answer with an error and a zero word.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rresp <= rps_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rresp <= is_mapped(s_axi_araddr) ? rps_pkg::RESP_OKAY
			                                       : rps_pkg::RESP_SLVERR;
		end
	end

	// Read data is captured once and then held until the master takes it.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rdata <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= read_word(s_axi_araddr, sel_lo_r, sel_hi_r);
		end
	end

	// ------------------------------------------------------------------
	// Pin steering
	// ------------------------------------------------------------------
	// Index 0 is pin 18 and index 3 is pin 21, as in the port bit order.
	logic [4:0] sel_pin [rps_pkg::NUM_PINS];

	assign sel_pin[0] = field(sel_lo_r, rps_pkg::LO_LSB);
	assign sel_pin[1] = field(sel_lo_r, rps_pkg::HI_LSB);
	assign sel_pin[2] = field(sel_hi_r, rps_pkg::LO_LSB);
	assign sel_pin[3] = field(sel_hi_r, rps_pkg::HI_LSB);

	// Registered outputs keep pad drivers glitch free while fields change.
	// zero keeps port control
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_out <= '0;
		end else begin
			for (int i = 0; i < rps_pkg::NUM_PINS; i++) begin
				pin_out[i] <= pick(sel_pin[i], periph_out, port_out[i]);
			end
		end
	end

	// The enable follows the same owner as the value, so a pin never
	// drives a peripheral level under a port enable or the reverse.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_oe <= '0;
		end else begin
			for (int i = 0; i < rps_pkg::NUM_PINS; i++) begin
				pin_oe[i] <= pick(sel_pin[i], periph_oe, port_oe[i]);
			end
		end
	end

	// small package never hands a pin to a peripheral
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_remapped <= '0;
		end else begin
			for (int i = 0; i < rps_pkg::NUM_PINS; i++) begin
				pin_remapped[i] <= LARGE_PKG &&
				                   sel_pin[i] != rps_pkg::SEL_NONE;
			end
		end
	end

endmodule

/* core/rps_pkg.sv */
package rps_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [3:0]  SEL_18_19_ADDR  = 4'h0;
	localparam logic [3:0]  SEL_20_21_ADDR  = 4'h4;
	localparam logic [3:0]  PKG_INFO_ADDR   = 4'h8;
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int          SEL_W           = 5;
	localparam int          HI_LSB          = 8;
	localparam int          LO_LSB          = 0;
	localparam logic [15:0] SEL_MASK        = 16'h1F1F;
	localparam logic [15:0] SEL_RESET       = 16'h0000;
	localparam logic [4:0]  SEL_NONE        = 5'h00;
	localparam int          NUM_PINS        = 4;
	localparam int          NUM_FUNCS       = 32;

	// ------------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

/* tb/rps_chk_asserts.sv */
`timescale 1ns/100ps
module rps_chk (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [3:0]  port_out,
	input wire logic [3:0]  port_oe,
	input wire logic [3:0]  pin_out,
	input wire logic [3:0]  pin_oe,
	input wire logic [3:0]  pin_remapped
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_read_zero:
	assert property (s_axi_rvalid |-> !s_axi_rdata[31:13] && !s_axi_rdata[7:5])
		else $error("reserved bits read back set");
	a_read_answer:
	assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
	a_read_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read answer dropped");
	a_write_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_reset_clear:
	assert property ($fell(srst) |-> pin_remapped == 4'h0 && pin_oe == 4'h0)
		else $error("pins not cleared by reset");
	a_gpio_out:
	assert property (!$past(srst) |-> !((pin_out ^ $past(port_out))
		& ~pin_remapped)) else $error("port value lost on free pin");
	a_gpio_oe:
	assert property (!$past(srst) |-> !((pin_oe ^ $past(port_oe))
		& ~pin_remapped)) else $error("port enable lost on free pin");
	a_remap_cause:
	assert property (!$past(srst) && $changed(pin_remapped) |->
		$past(s_axi_bvalid)) else $error("selection changed without write");
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, periph_out = 32'h0, periph_oe = 32'h0;
	logic [3:0]  port_out = 4'h0, port_oe = 4'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [3:0]  pin_out, pin_oe, pin_remapped;
	logic [31:0] sm_rdata, rd_sm;
	logic [1:0]  sm_rresp, sm_bresp, rsp_sm;
	logic [3:0]  sm_remapped;
	int          bad_count = 0;
	int          comparisons = 0;

	rps_out_select uut (.*);

	// Small package copy shares every input and answers in step with uut.
	rps_out_select #(
		.LARGE_PKG(1'b0)
	) uut_small (
		.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready(), .s_axi_bresp(sm_bresp), .s_axi_bvalid(),
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
		.s_axi_rdata(sm_rdata), .s_axi_rresp(sm_rresp), .s_axi_rvalid(),
		.s_axi_rready, .periph_out, .periph_oe, .port_out, .port_oe,
		.pin_out(), .pin_oe(), .pin_remapped(sm_remapped)
	);

	initial forever #2 sys_clk = ~sys_clk;

	task end_of_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// A bus answer that never comes ends the run as a failure.
	task cap(input int n);
		if (n >= 50) begin
			bad_count++;
			end_of_test();
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= be;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		rsp_sm = sm_bresp;
		cap(n);
	endtask

	task rdr(input logic [3:0] a);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		rd_sm = sm_rdata;
		rsp_sm = sm_rresp;
		cap(n);
	endtask

	task t_fields();
		rdr(rps_pkg::SEL_20_21_ADDR);
		chk(rd, 32'h0);
		chk({28'h0, pin_remapped}, 32'h0);
		wr(rps_pkg::SEL_18_19_ADDR, 32'hFFFF_FFFF, 4'hF);
		chk({30'h0, rsp}, {30'h0, rps_pkg::RESP_OKAY});
		chk({30'h0, rsp_sm}, {30'h0, rps_pkg::RESP_SLVERR});
		rdr(rps_pkg::SEL_18_19_ADDR);
		chk(rd, 32'h0000_1F1F);
		chk({rd_sm[29:0], rsp_sm}, {30'h0, rps_pkg::RESP_SLVERR});
		chk({28'h0, sm_remapped}, 32'h0);
		wr(rps_pkg::SEL_20_21_ADDR, 32'h0000_0504, 4'hF);
		wr(rps_pkg::SEL_18_19_ADDR, 32'h0000_0302, 4'hF);
		periph_out <= 32'h0000_0024;
		periph_oe <= 32'hFFFF_FFFF;
		rdr(rps_pkg::SEL_20_21_ADDR);
		chk(rd, 32'h0000_0504);
		chk({28'h0, pin_out}, 32'h9);
		chk({28'h0, pin_remapped}, 32'hF);
		wr(rps_pkg::SEL_20_21_ADDR, 32'h0000_FFFF, 4'h1);
		rdr(rps_pkg::SEL_20_21_ADDR);
		chk(rd, 32'h0000_051F);
	endtask

	task t_gpio();
		port_out <= 4'h5;
		wr(rps_pkg::SEL_18_19_ADDR, 32'h0000_0300, 4'hF);
		rdr(rps_pkg::SEL_18_19_ADDR);
		chk(rd, 32'h0000_0300);
		chk({24'h0, pin_remapped, pin_out}, 32'hE9);
		chk({28'h0, pin_oe}, 32'hE);
	endtask

	task t_unmapped();
		wr(4'h8, 32'h0000_1F1F, 4'hF);
		chk({30'h0, rsp}, {30'h0, rps_pkg::RESP_SLVERR});
		rdr(4'hC);
		chk({rd[29:0], rsp}, {30'h0, rps_pkg::RESP_SLVERR});
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_fields();
		t_gpio();
		t_unmapped();
		end_of_test();
	end
endmodule

bind rps_out_select rps_chk chk_i (.*);
